// ===== hdl/mrc_pkg.sv
/*
 Shared constants for the monitor register block and its 2-wire host.
 Assumes a 250 MHz ref_clk on both ends.
*/
package mrc_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 4;
   localparam int RST_PULSE_NS   = 20_000_000;
   localparam int RST_PULSE_CYC  = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LINK_PERIOD_NS = 64;
   localparam int QTR_CYC        = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
   // ==========================================================
   // Device register offsets
   localparam logic [7:0] OFS_TEST  = 8'h15;
   localparam logic [7:0] OFS_FAN   = 8'h19;
   localparam logic [7:0] OFS_MAKER = 8'h3E;
   localparam logic [7:0] OFS_REV   = 8'h3F;
   localparam logic [7:0] OFS_CTRL  = 8'h40;
   localparam logic [7:0] OFS_FLGA  = 8'h41;
   localparam logic [7:0] OFS_FLGB  = 8'h42;
   localparam logic [7:0] OFS_GATEA = 8'h43;
   localparam logic [7:0] OFS_GATEB = 8'h44;
   localparam logic [7:0] OFS_ICLR  = 8'h46;
   localparam logic [7:0] OFS_VID   = 8'h47;
   localparam logic [7:0] OFS_BADDR = 8'h48;
   localparam logic [7:0] OFS_VIDHI = 8'h49;
   localparam logic [7:0] OFS_TCFG  = 8'h4B;
   // ==========================================================
   // Reset values and fixed fields
   localparam logic [7:0] RST_ZERO     = 8'h00;
   localparam logic [7:0] RST_CTRL     = 8'h08;
   localparam logic [7:0] RST_FAN      = 8'hFF;
   localparam logic [7:0] RST_TCFG     = 8'h01;
   localparam logic [5:0] RST_BADDR_HI = 6'h0B;
   localparam logic [3:0] VID_TOP      = 4'h5;
   localparam logic [6:0] VIDHI_TOP    = 7'h40;
   localparam logic [7:0] GATE_SRC_MSK = 8'h7F;
   // ==========================================================
   // Bit positions
   localparam int CB_RUN = 0, CB_AEN = 1, CB_ACLR = 3, CB_SWRST = 4;
   localparam int CB_ICLR = 6, CB_INIT = 7, GB_RSTMODE = 7;
   localparam int IC_CLR = 7, FB_INTRUSION = 4;
   // Synchroniser lanes
   localparam int SY_SCL = 0, SY_SDA = 1, SY_A0 = 2, SY_A1 = 3, SY_VID = 4;
   localparam int SY_CPU_VOLTAGE_CODE_TOP_PIN = 8, SY_RST = 9, SY_INT = 10, SY_W = 11;
   // Bit counter marks
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK  = 4'h8;
   // ==========================================================
   // Host command registers (byte addresses)
   localparam logic [4:0] HOFS_CTRL   = 5'h00;
   localparam logic [4:0] HOFS_TARGET = 5'h04;
   localparam logic [4:0] HOFS_PTR    = 5'h08;
   localparam logic [4:0] HOFS_WDATA  = 5'h0C;
   localparam logic [4:0] HOFS_STATUS = 5'h10;
   localparam logic [4:0] HOFS_RDATA  = 5'h14;
   localparam int HC_GO = 8, ST_BUSY = 0, ST_NACK = 1;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      SL_IDLE = 3'h0, SL_ADDR = 3'h1, SL_PTR = 3'h2, SL_WDAT = 3'h3, SL_RDAT = 3'h4
   } mrc_slv_st_t;
   typedef enum logic [1:0] {
      OP_WRITE = 2'h0, OP_READ_CUR = 2'h1, OP_READ_AT = 2'h2
   } mrc_op_t;
   typedef enum logic [1:0] {
      SK_START = 2'h0, SK_TX = 2'h1, SK_RX = 2'h2, SK_STOP = 2'h3
   } mrc_seg_t;
endpackage

// ===== hdl/mrc_link_if.sv
/*
 2-wire link between the monitor device and its host.
 Assumes a pull-up on the data line; the host drives the clock alone.
*/
`timescale 1ns/1ps
interface mrc_link_if;
   logic scl;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda_host_o;
   logic sda_host_oe;
   wire  sda_line;
   // Open-drain resolution with pull-up
   assign sda_line = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));
   modport device (input scl, input sda_line, output sda_dev_o, output sda_dev_oe);
   modport host (output scl, input sda_line, output sda_host_o, output sda_host_oe);
endinterface

// ===== hdl/mrc_monitor_dev.sv
/*
 Device end: 2-wire slave, register map, reset and control logic.
 Assumes all pins are asynchronous to ref_clk; open-drain lines resolved outside.
*/
// Register access over Avalon-MM is this design's own decision.
// Functional notes
// - Write is address, pointer, then data
// - Address-only read returns byte at pointer
// - Pointer write, restart, then one-byte read
// - Power-on address is prefix plus straps
// - Address register write; low bits follow straps
// - Power-on loads every mapped register default
// - Monitoring stays off until software starts
// - Power-on drives reset line low 20 ms
// - Control bit 4 pulses reset line, self-clears
// - Software pulse needs reset-mode gate bit 7
// - Control bit 7 reinitialises, keeps fan level
// - External reset low: hold line, reinitialise
// - Control bit 0 runs or stops monitoring
// - Standby still watches reset and intrusion
// - Control bit 1 gates alert output
// - Control bit 3 clears alert, halts monitoring
// - Control bit 6 drives intrusion pin low
// - Intrusion clear bit 7 clears indication
// - Code registers reflect live code pins
// - Host never writes factory test register; the device accepts writes to it at 8'h15
// - Alert active low, gated by control/masks
// - Intrusion pin high latched, cleared low
`timescale 1ns/1ps
module mrc_monitor_dev
   import mrc_pkg::*;
#(
   parameter int         RST_PULSE_CYC_P = RST_PULSE_CYC,
   parameter logic [7:0] MAKER_CODE      = 8'h5A,  // Arbitrary value
   parameter logic [7:0] REV_CODE        = 8'h10   // Arbitrary value
)(
   // Clock, reset, enable
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // Serial link
   mrc_link_if.device      lnk,
   // Strap and code pins
   input  wire logic       addr_strap_low,
   input  wire logic       addr_strap_high,
   input  wire logic [3:0] cpu_voltage_code_pins,
   input  wire logic       cpu_voltage_code_top_pin,
   // Reset line, open drain
   input  wire logic       rst_line_i,
   output logic            rst_line_o,
   output logic            rst_line_oe,
   // Intrusion pin, open drain
   input  wire logic       intrusion_input_i,
   output logic            intrusion_input_o,
   output logic            intrusion_input_oe,
   // Status outputs
   output logic            alert_n,
   output logic            monitor_run
);
   localparam int RCW = $clog2(RST_PULSE_CYC_P + 1);

   logic [SY_W-1:0] syn_in, syn1_q, syn2_q;
   logic            scl_p_q, sda_p_q;
   logic            scl_rise, scl_fall, bus_start, bus_stop;
   mrc_slv_st_t     st_q, nxt_q;
   logic [3:0]      cnt_q;
   logic [7:0]      sh_q, tx_q, ptr_q, rd_data;
   logic            sda_oe_q, wr_stb_q;
   logic [6:0]      my_addr;
   logic [7:0]      cfg_q, gate_a_q, gate_b_q, tcfg_q, test_q, fan_q, flags_b;
   logic [5:0]      baddr_hi_q;
   logic            intr_seen_q, init_now, sw_go, hw_evt;
   logic [RCW-1:0]  rcnt_q;
   logic [2:0]      drv_hist_q;
   logic            alert_n_q, run_q;

   // ==========================================================
   // Input synchronisers
   assign syn_in = {intrusion_input_i, rst_line_i, cpu_voltage_code_top_pin,
                    cpu_voltage_code_pins, addr_strap_high, addr_strap_low,
                    lnk.sda_line, lnk.scl};
   generate
      for (genvar i = 0; i < SY_W; i++) begin : g_sync
         // Two stages per lane
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               syn1_q[i] <= 1'b1;
               syn2_q[i] <= 1'b1;
            end else if (ce) begin
               syn1_q[i] <= syn_in[i];
               syn2_q[i] <= syn1_q[i];
            end
         end
      end
   endgenerate

   // Previous link levels for edge detection
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else if (ce) begin
         scl_p_q <= syn2_q[SY_SCL];
         sda_p_q <= syn2_q[SY_SDA];
      end
   end

   // Link events
   assign scl_rise  = syn2_q[SY_SCL] && !scl_p_q;
   assign scl_fall  = !syn2_q[SY_SCL] && scl_p_q;
   assign bus_start = syn2_q[SY_SCL] && scl_p_q && sda_p_q && !syn2_q[SY_SDA];
   assign bus_stop  = syn2_q[SY_SCL] && scl_p_q && !sda_p_q && syn2_q[SY_SDA];
   assign my_addr   = {baddr_hi_q[4:0], syn2_q[SY_A1], syn2_q[SY_A0]};

   // ==========================================================
   // Serial slave
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_q     <= SL_IDLE;
         nxt_q    <= SL_IDLE;
         cnt_q    <= '0;
         sh_q     <= RST_ZERO;
         tx_q     <= RST_ZERO;
         ptr_q    <= RST_ZERO;
         sda_oe_q <= 1'b0;
         wr_stb_q <= 1'b0;
      end else if (ce) begin
         wr_stb_q <= 1'b0;
         if (bus_start) begin
            st_q     <= SL_ADDR;
            cnt_q    <= '1;  // Start's own clock fall wraps this to zero
            sda_oe_q <= 1'b0;
         end else if (bus_stop) begin
            st_q     <= SL_IDLE;
            sda_oe_q <= 1'b0;
         end else if (st_q != SL_IDLE) begin
            if (scl_rise && cnt_q < BIT_ACK)
               sh_q <= {sh_q[6:0], syn2_q[SY_SDA]};
            if (scl_rise && cnt_q == BIT_ACK && st_q == SL_RDAT && syn2_q[SY_SDA])
               nxt_q <= SL_IDLE;  // Master refused more data
            if (scl_fall) begin
               if (cnt_q == BIT_LAST) begin
                  cnt_q <= BIT_ACK;
                  unique case (st_q)
                     SL_ADDR: begin
                        sda_oe_q <= (sh_q[7:1] == my_addr);
                        if (sh_q[7:1] != my_addr)
                           nxt_q <= SL_IDLE;
                        else if (sh_q[0])
                           nxt_q <= SL_RDAT;
                        else
                           nxt_q <= SL_PTR;
                     end
                     SL_PTR: begin
                        ptr_q    <= sh_q;
                        sda_oe_q <= 1'b1;
                        nxt_q    <= SL_WDAT;
                     end
                     SL_WDAT: begin
                        wr_stb_q <= 1'b1;
                        sda_oe_q <= 1'b1;
                        nxt_q    <= SL_WDAT;
                     end
                     SL_RDAT: begin
                        sda_oe_q <= 1'b0;
                        nxt_q    <= SL_RDAT;
                     end
                  endcase
               end else if (cnt_q == BIT_ACK) begin
                  cnt_q <= '0;
                  st_q  <= nxt_q;
                  tx_q  <= rd_data;
                  sda_oe_q <= (nxt_q == SL_RDAT) && !rd_data[7];
               end else begin
                  cnt_q <= cnt_q + 4'h1;
                  tx_q  <= {tx_q[6:0], 1'b0};
                  sda_oe_q <= (st_q == SL_RDAT) && !tx_q[6];
               end
            end
         end
      end
   end
   assign lnk.sda_dev_oe = sda_oe_q;
   assign lnk.sda_dev_o  = 1'b0;

   // ==========================================================
   // Register read mux
   always_comb begin
      flags_b = RST_ZERO;
      flags_b[FB_INTRUSION] = intr_seen_q;
      case (ptr_q)
         OFS_TEST:  rd_data = test_q;
         OFS_FAN:   rd_data = fan_q;
         OFS_MAKER: rd_data = MAKER_CODE;
         OFS_REV:   rd_data = REV_CODE;
         OFS_CTRL:  rd_data = cfg_q;
         OFS_FLGB:  rd_data = flags_b;
         OFS_GATEA: rd_data = gate_a_q;
         OFS_GATEB: rd_data = gate_b_q;
         OFS_VID:   rd_data = {VID_TOP, syn2_q[SY_VID+3:SY_VID]};
         OFS_BADDR: rd_data = {baddr_hi_q, syn2_q[SY_A1], syn2_q[SY_A0]};
         OFS_VIDHI: rd_data = {VIDHI_TOP, syn2_q[SY_CPU_VOLTAGE_CODE_TOP_PIN]};
         OFS_TCFG:  rd_data = tcfg_q;
         default:   rd_data = RST_ZERO;
      endcase
   end

   // ==========================================================
   // Register file
   assign init_now = (wr_stb_q && ptr_q == OFS_CTRL && sh_q[CB_INIT]) || hw_evt;
   assign sw_go    = cfg_q[CB_SWRST] && gate_b_q[GB_RSTMODE] && rcnt_q == '0;

   // Defaults on power-on, init bit or external reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n || (ce && init_now)) begin
         cfg_q      <= RST_CTRL;
         gate_a_q   <= RST_ZERO;
         gate_b_q   <= RST_ZERO;
         tcfg_q     <= RST_TCFG;
         test_q     <= RST_ZERO;
         baddr_hi_q <= RST_BADDR_HI;
      end else if (ce) begin
         if (sw_go)
            cfg_q[CB_SWRST] <= 1'b0;
         if (wr_stb_q) begin
            case (ptr_q)
               OFS_CTRL:  cfg_q      <= sh_q;
               OFS_GATEA: gate_a_q   <= sh_q;
               OFS_GATEB: gate_b_q   <= sh_q;
               OFS_TCFG:  tcfg_q     <= sh_q;
               OFS_TEST:  test_q     <= sh_q;
               OFS_BADDR: baddr_hi_q <= sh_q[7:2];
               default:   ;
            endcase
         end
      end
   end

   // Fan level survives init and external reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         fan_q <= RST_FAN;
      else if (ce && wr_stb_q && ptr_q == OFS_FAN)
         fan_q <= sh_q;
   end

   // Intrusion indication, set wins over clear
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         intr_seen_q <= 1'b0;
      else if (ce) begin
         if (syn2_q[SY_INT] && !cfg_q[CB_ICLR])
            intr_seen_q <= 1'b1;
         else if ((wr_stb_q && ptr_q == OFS_ICLR && sh_q[IC_CLR]) || init_now)
            intr_seen_q <= 1'b0;
      end
   end
   assign intrusion_input_oe = cfg_q[CB_ICLR];
   assign intrusion_input_o  = 1'b0;

   // ==========================================================
   // Reset line pulse
   assign hw_evt = !syn2_q[SY_RST] && rcnt_q == '0 && drv_hist_q == '0;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rcnt_q     <= RCW'(RST_PULSE_CYC_P);
         drv_hist_q <= '1;
      end else if (ce) begin
         drv_hist_q <= {drv_hist_q[1:0], rcnt_q != '0};
         if (rcnt_q != '0)
            rcnt_q <= rcnt_q - RCW'(1);
         else if (sw_go || hw_evt)
            rcnt_q <= RCW'(RST_PULSE_CYC_P);
      end
   end
   assign rst_line_oe = rcnt_q != '0;
   assign rst_line_o  = 1'b0;

   // ==========================================================
   // Alert and run outputs
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         alert_n_q <= 1'b1;
         run_q     <= 1'b0;
      end else if (ce) begin
         alert_n_q <= !(cfg_q[CB_AEN] && !cfg_q[CB_ACLR]
                        && |(flags_b & ~gate_b_q & GATE_SRC_MSK));
         run_q     <= cfg_q[CB_RUN] && !cfg_q[CB_ACLR];
      end
   end
   assign alert_n     = alert_n_q;
   assign monitor_run = run_q;
endmodule

// ===== hdl/mrc_monitor_host.sv
/*
 Host end: 2-wire master driven from Avalon-MM command registers.
 Assumes the device never stretches the clock; scl is made by a divider.
*/
`timescale 1ns/1ps
module mrc_monitor_host
   import mrc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Serial link
   mrc_link_if.host         lnk
);
   localparam int QCW = $clog2(QTR_CYC + 1);

   logic           ack_q, busy_q, nack_q, scl_q, sda_oe_q, sda1_q, sda2_q, go;
   logic [31:0]    rdd_q;
   logic [1:0]     op_q, q_q;
   logic [6:0]     target_q;
   logic [7:0]     ptr_q, wdat_q, rdat_q, txb_q, rsh_q, tx_byte;
   logic [2:0]     seg_q;
   logic [3:0]     bit_q;
   logic [QCW-1:0] tick_q;
   mrc_seg_t       kind;

   // Segment kind per operation and index
   function automatic mrc_seg_t seg_kind(input logic [1:0] op, input logic [2:0] s);
      mrc_seg_t k;
      k = SK_STOP;
      if (s == 3'h0 || (op == OP_READ_AT && s == 3'h3))
         k = SK_START;
      else if ((op == OP_READ_CUR && s == 3'h2) || (op == OP_READ_AT && s == 3'h5))
         k = SK_RX;
      else if ((op == OP_WRITE && s < 3'h4) || (op == OP_READ_CUR && s == 3'h1)
               || (op == OP_READ_AT && s < 3'h5))
         k = SK_TX;
      return k;
   endfunction

   // Byte sent in a transmit segment
   function automatic logic [7:0] seg_byte(input logic [1:0] op, input logic [2:0] s);
      logic [7:0] b;
      b = {target_q, 1'b0};
      if (s == 3'h2)
         b = (op == OP_READ_CUR) ? RST_ZERO : ptr_q;
      else if (s == 3'h3)
         b = wdat_q;
      else if ((op == OP_READ_CUR && s == 3'h1) || s == 3'h4)
         b = {target_q, 1'b1};
      return b;
   endfunction

   // ==========================================================
   // Avalon slave, one wait cycle per access
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign avs_readdata    = rdd_q;
   assign go = avs_write && ack_q && avs_address == HOFS_CTRL
               && avs_writedata[HC_GO] && !busy_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ack_q    <= 1'b0;
         rdd_q    <= '0;
         op_q     <= OP_WRITE;
         target_q <= '0;
         ptr_q    <= RST_ZERO;
         wdat_q   <= RST_ZERO;
      end else if (ce) begin
         ack_q <= (avs_read || avs_write) && !ack_q;
         if (avs_read && !ack_q) begin
            rdd_q <= '0;
            case (avs_address)
               HOFS_CTRL:   rdd_q[1:0] <= op_q;
               HOFS_TARGET: rdd_q[6:0] <= target_q;
               HOFS_PTR:    rdd_q[7:0] <= ptr_q;
               HOFS_WDATA:  rdd_q[7:0] <= wdat_q;
               HOFS_STATUS: rdd_q[ST_NACK:ST_BUSY] <= {nack_q, busy_q};
               HOFS_RDATA:  rdd_q[7:0] <= rdat_q;
               default:     ;
            endcase
         end
         if (avs_write && ack_q && !busy_q) begin
            case (avs_address)
               HOFS_CTRL:   op_q     <= avs_writedata[1:0];
               HOFS_TARGET: target_q <= avs_writedata[6:0];
               HOFS_PTR:    ptr_q    <= avs_writedata[7:0];
               HOFS_WDATA:  wdat_q   <= avs_writedata[7:0];
               default:     ;
            endcase
         end
      end
   end

   // ==========================================================
   // Data line synchroniser
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sda1_q <= 1'b1;
         sda2_q <= 1'b1;
      end else if (ce) begin
         sda1_q <= lnk.sda_line;
         sda2_q <= sda1_q;
      end
   end

   // ==========================================================
   // Link engine, four quarters per bit slot
   assign kind = seg_kind(op_q, seg_q);
   assign tx_byte = seg_byte(op_q, seg_q);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         busy_q   <= 1'b0;
         nack_q   <= 1'b0;
         scl_q    <= 1'b1;
         sda_oe_q <= 1'b0;
         seg_q    <= '0;
         bit_q    <= '0;
         q_q      <= '0;
         tick_q   <= '0;
         txb_q    <= RST_ZERO;
         rsh_q    <= RST_ZERO;
         rdat_q   <= RST_ZERO;
      end else if (ce) begin
         if (go) begin
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            seg_q  <= '0;
            bit_q  <= '0;
            q_q    <= '0;
            tick_q <= '0;
         end else if (busy_q && tick_q != QCW'(QTR_CYC - 1)) begin
            tick_q <= tick_q + QCW'(1);
         end else if (busy_q) begin
            tick_q <= '0;
            q_q    <= q_q + 2'h1;
            unique case (q_q)
               2'h0: begin
                  scl_q <= 1'b0;
                  unique case (kind)
                     SK_START: sda_oe_q <= 1'b0;
                     SK_STOP:  sda_oe_q <= 1'b1;
                     SK_RX:    sda_oe_q <= 1'b0;  // Single byte, answered with nack
                     SK_TX: begin
                        if (bit_q == '0) begin
                           txb_q    <= tx_byte;
                           sda_oe_q <= !tx_byte[7];
                        end else
                           sda_oe_q <= (bit_q != BIT_ACK) && !txb_q[7];
                     end
                  endcase
               end
               2'h1: scl_q <= 1'b1;
               2'h2: begin
                  if (kind == SK_START)
                     sda_oe_q <= 1'b1;
                  else if (kind == SK_STOP)
                     sda_oe_q <= 1'b0;
                  else if (kind == SK_RX && bit_q < BIT_ACK)
                     rsh_q <= {rsh_q[6:0], sda2_q};
                  else if (kind == SK_TX && bit_q == BIT_ACK && sda2_q)
                     nack_q <= 1'b1;
               end
               2'h3: begin
                  if (kind != SK_STOP)
                     scl_q <= 1'b0;
                  if (kind == SK_STOP) begin
                     busy_q <= 1'b0;
                  end else if ((kind == SK_TX || kind == SK_RX) && bit_q != BIT_ACK) begin
                     bit_q <= bit_q + 4'h1;
                     if (kind == SK_TX)
                        txb_q <= {txb_q[6:0], 1'b0};
                  end else begin
                     bit_q <= '0;
                     if (kind == SK_RX)
                        rdat_q <= rsh_q;
                     if (nack_q)
                        seg_q <= (op_q == OP_WRITE) ? 3'h4 :
                                 (op_q == OP_READ_CUR) ? 3'h3 : 3'h6;
                     else
                        seg_q <= seg_q + 3'h1;
                  end
               end
            endcase
         end
      end
   end

   assign lnk.scl         = scl_q;
   assign lnk.sda_host_oe = sda_oe_q;
   assign lnk.sda_host_o  = 1'b0;
endmodule

// ===== testbench/mrc_monitor_asserts.sv
/*
 Checker for the device pins of the monitor link.
 Assumes one ref_clk domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module mrc_monitor_asserts
   import mrc_pkg::*;
#(parameter int PC = 20)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Link and device pins
   input wire logic scl,
   input wire logic sda_dev_oe,
   input wire logic rst_line_i,
   input wire logic rst_line_o,
   input wire logic rst_line_oe,
   input wire logic intrusion_input_o,
   input wire logic intrusion_input_oe,
   input wire logic alert_n,
   input wire logic monitor_run
);
   logic [31:0] cnt_q;
   // Cycles the reset line has been pulled
   always_ff @(posedge ref_clk) begin
      cnt_q <= (!rst_n || !rst_line_oe) ? 32'h0 : cnt_q + 32'h1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_por; $rose(rst_n) |-> rst_line_oe; endproperty
   a_por: assert property (p_por) else $error("no pull at start");
   property p_len; $fell(rst_line_oe) |-> cnt_q >= PC - 1; endproperty
   a_len: assert property (p_len) else $error("pull too short");
   property p_run; $rose(rst_n) |-> !monitor_run; endproperty
   a_run: assert property (p_run) else $error("runs at start");
   property p_alrt; $rose(rst_n) |-> alert_n; endproperty
   a_alrt: assert property (p_alrt) else $error("alert at start");
   property p_iclr; $rose(rst_n) |-> !intrusion_input_oe; endproperty
   a_iclr: assert property (p_iclr) else $error("intrusion driven at start");
   property p_rlow; rst_line_oe |-> !rst_line_o; endproperty
   a_rlow: assert property (p_rlow) else $error("reset line driven high");
   property p_ilow; intrusion_input_oe |-> !intrusion_input_o; endproperty
   a_ilow: assert property (p_ilow) else $error("intrusion driven high");
   property p_ext; $fell(rst_line_i) && !rst_line_oe |-> ##[1:8] rst_line_oe; endproperty
   a_ext: assert property (p_ext) else $error("outside pull not held");
   property p_sda; $changed(sda_dev_oe) |-> !scl; endproperty
   a_sda: assert property (p_sda) else $error("data moved with clock high");
endmodule

// ===== testbench/tb_monitor_register_and_reset_control.sv
/*
 Bench for the monitor device and its 2-wire host, joined by the link.
 Assumes the host's Avalon-MM port is the only way to the device.
*/
`timescale 1ns/1ps
module tb_monitor_register_and_reset_control
   import mrc_pkg::*;
;
   logic ref_clk = 0, rst_n = 0, rd = 0, wr = 0, ext = 0, intr = 0, vt = 1;
   logic [4:0] adr = 0;
   logic [31:0] wd = 0, q, st, rdata;
   logic [7:0] rises = 0, base;
   logic [6:0] ta;
   logic wq, rlo, rloe, ilo, iloe, alert_n, run;
   logic [7:0] dp [7] = '{OFS_CTRL, OFS_FAN, OFS_TCFG, OFS_BADDR, OFS_VID, OFS_VIDHI, OFS_TEST};
   logic [7:0] de [7] = '{RST_CTRL, RST_FAN, RST_TCFG, 8'h2E, 8'h5A, 8'h81, RST_ZERO};
   int n_compared = 0, fail_count = 0, cyc = 0;
   // Open-drain reset line with pull-up; intrusion line driven by intr
   wire rli = !(rloe && !rlo) && !ext;
   wire ili = intr && !(iloe && !ilo);
   mrc_link_if lk ();
   mrc_monitor_dev #(.RST_PULSE_CYC_P(20)) u_mrc_monitor_dev (.ref_clk(ref_clk),
      .rst_n(rst_n), .ce(1'b1), .lnk(lk), .addr_strap_low(1'b0), .addr_strap_high(1'b1),
      .cpu_voltage_code_pins(4'hA), .cpu_voltage_code_top_pin(vt), .rst_line_i(rli),
      .rst_line_o(rlo), .rst_line_oe(rloe), .intrusion_input_i(ili), .intrusion_input_o(ilo),
      .intrusion_input_oe(iloe), .alert_n(alert_n), .monitor_run(run));
   mrc_monitor_host u_mrc_monitor_host (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1),
      .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_readdata(rdata), .avs_waitrequest(wq), .lnk(lk));
   mrc_monitor_asserts #(.PC(20)) u_mrc_monitor_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
      .scl(lk.scl), .sda_dev_oe(lk.sda_dev_oe), .rst_line_i(rli), .rst_line_o(rlo),
      .rst_line_oe(rloe), .intrusion_input_o(ilo), .intrusion_input_oe(iloe),
      .alert_n(alert_n), .monitor_run(run));
   // Clock and pulse counter
   initial forever #2 ref_clk = ~ref_clk;
   always @(posedge rloe) rises <= rises + 8'h1;
   // Hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      if (fail_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, s);
      end
   endtask
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= d;
      do @(negedge ref_clk); while (wq !== 1'b0);
      @(posedge ref_clk);
      q = rdata;
      wr <= 0;
      rd <= 0;
   endtask
   // One link transfer, polled to completion
   task automatic op(input logic [1:0] o, input logic [7:0] p, input logic [7:0] d);
      av(1, HOFS_TARGET, {25'h0, ta});
      av(1, HOFS_PTR, {24'h0, p});
      av(1, HOFS_WDATA, {24'h0, d});
      av(1, HOFS_CTRL, 32'h100 | {30'h0, o});
      do av(0, HOFS_STATUS, 32'h0); while (q[ST_BUSY] !== 1'b0);
      st = q;
      av(0, HOFS_RDATA, 32'h0);
   endtask
   task automatic w(input logic [7:0] p, input logic [7:0] d);
      op(OP_WRITE, p, d);
   endtask
   task automatic r(input string nm, input logic [7:0] p, input logic [7:0] e);
      op(OP_READ_AT, p, 8'h00);
      chk(nm, q[7:0], e);
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1;
      ta = 7'h2E;
      repeat (40) @(posedge ref_clk);
      for (int i = 0; i < 7; i++) r("default", dp[i], de[i]);
      vt <= 0;
      w(OFS_VIDHI, 8'hFF);
      r("vidhi", OFS_VIDHI, 8'h80);
      w(OFS_TCFG, 8'h03);
      r("tcfg", OFS_TCFG, 8'h03);
      op(OP_READ_CUR, 8'h00, 8'h00);
      chk("current", q[7:0], 8'h03);
      base = rises;
      w(OFS_CTRL, 8'h10);
      w(OFS_CTRL, 8'h00);
      chk("pulses", rises - base, 8'h00);
      w(OFS_GATEB, 8'h80);
      w(OFS_CTRL, 8'h10);
      repeat (40) @(posedge ref_clk);
      chk("pulses", rises - base, 8'h01);
      r("ctrl", OFS_CTRL, 8'h00);
      r("gate", OFS_GATEB, 8'h80);
      intr <= 1;
      w(OFS_CTRL, 8'h02);
      chk("alert_n", {7'h0, alert_n}, 8'h00);
      w(OFS_CTRL, 8'h0A);
      chk("alert_n", {7'h0, alert_n}, 8'h01);
      r("flags", OFS_FLGB, 8'h10);
      w(OFS_CTRL, 8'h40);
      chk("intrusion_oe", {7'h0, iloe}, 8'h01);
      intr <= 0;
      w(OFS_ICLR, 8'h80);
      r("flags", OFS_FLGB, 8'h00);
      w(OFS_CTRL, 8'h01);
      chk("run", {7'h0, run}, 8'h01);
      w(OFS_BADDR, 8'h90);
      ta = 7'h12;
      r("baddr", OFS_BADDR, 8'h92);
      w(OFS_FAN, 8'h33);
      ext <= 1;
      repeat (10) @(posedge ref_clk);
      ext <= 0;
      repeat (40) @(posedge ref_clk);
      op(OP_READ_AT, OFS_CTRL, 8'h00);
      chk("nack", {7'h0, st[ST_NACK]}, 8'h01);
      ta = 7'h2E;
      r("fan", OFS_FAN, 8'h33);
      r("gate", OFS_GATEB, 8'h00);
      chk("run", {7'h0, run}, 8'h00);
      w(OFS_GATEA, 8'h55);
      w(OFS_CTRL, 8'h80);
      r("gate", OFS_GATEA, 8'h00);
      r("ctrl", OFS_CTRL, 8'h08);
      av(0, 5'h18, 32'h0);
      chk("unmapped", q[7:0], 8'h00);
      print_verdict();
   end
endmodule
